// *** psm_ctrl.sv ***
// Power saving mode controller: slow, wait, halt, active-halt and auto-wake halt
`default_nettype none
module psm_ctrl
  import psm_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [7:0]        reg_rdata,
  input  wire logic         instr_valid,
  input  wire logic [7:0]   instr_opcode,
  input  wire logic         sleep_until_irq_instr,
  input  wire logic         irq_pending,
  input  wire logic         wake_irq,
  input  wire logic         rtc_irq,
  input  wire logic         watchdog_enabled,
  input  wire logic         watchdog_halt_option,
  input  wire logic         startup_long_option,
  input  wire logic         rc_osc_clk,
  output psm_clk_gate_type  clk_gate,
  output psm_mask_force_type mask_force,
  output logic              cpu_resume,
  output logic              watchdog_reset_req,
  output logic              rc_osc_enable,
  output logic              auto_wake_irq,
  output logic              timer_capture_input_one
);

  // Register state
  psm_state_type state_reg;
  psm_state_type state_next;
  logic [3:0]    main_clk_reg;
  logic [1:0]    awu_csr_reg;
  logic          auto_wake_flag_reg;
  logic [7:0]    awu_presc_reg;
  logic [7:0]    rdata_reg;
  logic [3:0]    slow_cnt_reg;
  logic [12:0]   start_cnt_reg;
  logic [12:0]   start_cnt_next;
  logic [13:0]   awu_cnt_reg;
  logic          rc_meta_reg;
  logic          rc_sync_reg;
  logic          rc_prev_reg;
  logic          capture_reg;
  logic          resume_reg;
  logic          wdg_req_reg;
  psm_mask_force_type mask_reg;
  psm_mask_force_type mask_next;

  // Field decode
  wire       slow_select_bit     = main_clk_reg[PSM_SLOW_SEL_BIT];
  wire [1:0] slow_divider_select = main_clk_reg[PSM_SLOW_DIV_LSB +: 2];
  wire       osc_irq_enable      = main_clk_reg[PSM_OSC_IRQ_BIT];
  wire       auto_wake_enable    = awu_csr_reg[PSM_AWU_EN_BIT];
  wire       auto_wake_measure   = awu_csr_reg[PSM_AWU_MEAS_BIT];

  // Bus decode
  wire wr_main  = reg_write && (reg_addr == PSM_ADDR_MAIN_CLK);
  wire wr_csr   = reg_write && (reg_addr == PSM_ADDR_AWU_CSR);
  wire wr_presc = reg_write && (reg_addr == PSM_ADDR_AWU_PRESC);
  wire rd_csr   = reg_read && (reg_addr == PSM_ADDR_AWU_CSR);

  // Instruction decode
  wire halt_exec = instr_valid && (instr_opcode == PSM_HALT_OPCODE);
  wire wait_exec = sleep_until_irq_instr;

  // Slow divider: tick once every 2 << select cycles
  wire [3:0] slow_mask = 4'((5'h2 << slow_divider_select) - 5'h1);
  wire       slow_tick = !slow_select_bit || ((slow_cnt_reg & slow_mask) == slow_mask);

  // RC edge and auto-wake terminal count of 64 times the prescaler
  wire        rc_rise    = rc_sync_reg && !rc_prev_reg;
  wire [13:0] awu_target = 14'(PSM_AWU_FIXED_DIV * {6'h0, awu_presc_reg});
  wire        awu_zero   = (awu_presc_reg == 8'h00);
  wire        awu_done   = (state_reg == PSM_AWU_HALT) &&
                           (awu_zero || (rc_rise && (awu_cnt_reg == awu_target - 14'h1)));
  wire [12:0] start_load = startup_long_option ? PSM_LONG_CNT : PSM_SHORT_CNT;
  wire        wdg_on_halt = watchdog_enabled && !watchdog_halt_option;

  // Mode sequencing
  always_comb
  begin
    state_next     = state_reg;
    start_cnt_next = start_cnt_reg;
    mask_next      = '0;
    case (state_reg)
      PSM_RUN:
      begin
        if (wait_exec)
        begin
          state_next = PSM_WAIT;
          mask_next  = '{load: 1'b1, level: PSM_MASK_ENABLE};
        end
        else if (halt_exec && osc_irq_enable)
        begin
          state_next = PSM_ACTIVE_HALT;
          mask_next  = '{load: 1'b1, level: PSM_MASK_CLEARED};
        end
        else if (halt_exec && !wdg_on_halt)
        begin
          state_next = auto_wake_enable ? PSM_AWU_HALT : PSM_HALT;
          mask_next  = '{load: 1'b1, level: PSM_MASK_ENABLE};
        end
      end
      PSM_WAIT:
        if (irq_pending)
          state_next = PSM_RUN;
      PSM_ACTIVE_HALT:
        if (rtc_irq || wake_irq)
          state_next = PSM_RUN;
      PSM_HALT:
        if (wake_irq)
        begin
          state_next     = PSM_STARTUP;
          start_cnt_next = start_load;
        end
      PSM_AWU_HALT:
        if (wake_irq || awu_done)
        begin
          state_next     = PSM_STARTUP;
          start_cnt_next = start_load;
        end
      PSM_STARTUP:
        if (start_cnt_reg == 13'h0)
          state_next = PSM_RUN;
        else
          start_cnt_next = start_cnt_reg - 13'h1;
      default:
        state_next = PSM_RUN;
    endcase
  end

  // State, start-up counter and mask force; reset exit also runs the start-up delay
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= PSM_STARTUP;
      start_cnt_reg <= PSM_LONG_CNT;
      mask_reg      <= '0;
      resume_reg    <= 1'b0;
      wdg_req_reg   <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      start_cnt_reg <= start_cnt_next;
      mask_reg      <= mask_next;
      resume_reg    <= (state_reg != PSM_RUN) && (state_next == PSM_RUN);
      wdg_req_reg   <= (state_reg == PSM_RUN) && halt_exec && !osc_irq_enable
                       && wdg_on_halt;
    end
  end

  // Slow divider counter, free running so the division is exact
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      slow_cnt_reg <= 4'h0;
    else
      slow_cnt_reg <= slow_cnt_reg + 4'h1;
  end

  // RC oscillator synchroniser; it is an unrelated clock
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rc_meta_reg <= 1'b0;
      rc_sync_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end
    else
    begin
      rc_meta_reg <= rc_osc_clk;
      rc_sync_reg <= rc_meta_reg;
      rc_prev_reg <= rc_sync_reg;
    end
  end

  // Auto-wake period counter, cleared outside auto-wake halt
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      awu_cnt_reg <= 14'h0;
    else if (state_reg != PSM_AWU_HALT)
      awu_cnt_reg <= 14'h0;
    else if (rc_rise)
      awu_cnt_reg <= awu_cnt_reg + 14'h1;
  end

  // Software registers; mode changes never touch slow settings
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      main_clk_reg  <= PSM_MAIN_CLK_RST;
      awu_csr_reg   <= PSM_AWU_CSR_RST;
      awu_presc_reg <= PSM_AWU_PRESC_RST;
    end
    else
    begin
      if (wr_main)
        main_clk_reg <= reg_wdata[3:0];
      if (wr_csr)
        awu_csr_reg <= reg_wdata[1:0];
      if (wr_presc)
        awu_presc_reg <= reg_wdata;
    end
  end

  // Flag: hardware set wins over the read clear in the same cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      auto_wake_flag_reg <= 1'b0;
    else if (awu_done)
      auto_wake_flag_reg <= 1'b1;
    else if (rd_csr)
      auto_wake_flag_reg <= 1'b0;
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= 8'h00;
    else if (!reg_read)
      rdata_reg <= 8'h00;
    else if (reg_addr == PSM_ADDR_MAIN_CLK)
      rdata_reg <= {4'h0, main_clk_reg};
    else if (reg_addr == PSM_ADDR_AWU_CSR)
      rdata_reg <= {5'h0, auto_wake_flag_reg, awu_csr_reg};
    else if (reg_addr == PSM_ADDR_AWU_PRESC)
      rdata_reg <= awu_presc_reg;
    else
      rdata_reg <= 8'h00;
  end

  // Measurement path only in run mode; registered for a clean timer input
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      capture_reg <= 1'b0;
    else
      capture_reg <= auto_wake_measure && (state_reg == PSM_RUN) && rc_sync_reg;
  end

  // Clock gating; halt and auto-wake halt stop the oscillator and rtc, active-halt keeps both
  assign clk_gate.cpu    = (state_reg == PSM_RUN) && slow_tick;
  assign clk_gate.periph = ((state_reg == PSM_RUN) || (state_reg == PSM_WAIT))
                           && slow_tick;
  assign clk_gate.rtc    = (state_reg != PSM_HALT) && (state_reg != PSM_AWU_HALT);
  assign clk_gate.osc    = (state_reg != PSM_HALT) && (state_reg != PSM_AWU_HALT);

  // Outputs
  assign mask_force              = mask_reg;
  assign cpu_resume              = resume_reg;
  assign watchdog_reset_req      = wdg_req_reg;
  assign rc_osc_enable           = (state_reg == PSM_AWU_HALT) ||
                                   (auto_wake_measure && (state_reg == PSM_RUN));
  assign auto_wake_irq           = auto_wake_flag_reg;
  assign timer_capture_input_one = capture_reg;
  assign reg_rdata               = rdata_reg;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_wait_mask_force: assert property (
    (state_reg == PSM_RUN) && wait_exec |=> mask_reg.load && (mask_reg.level == 2'h2)
      && (state_reg == PSM_WAIT))
    else $error("wait entry did not force mask level");
  a_active_mask_clear: assert property (
    (state_reg == PSM_RUN) && !wait_exec && halt_exec && osc_irq_enable
      |=> mask_reg.load && (mask_reg.level == 2'h0) && (state_reg == PSM_ACTIVE_HALT))
    else $error("active-halt entry did not clear mask");
  a_halt_osc_off: assert property (
    (state_reg == PSM_HALT) |-> !clk_gate.osc && !clk_gate.cpu && !clk_gate.periph)
    else $error("clock running in halt");
  a_wait_cpu_stop: assert property (
    (state_reg == PSM_WAIT) |-> !clk_gate.cpu && (clk_gate.periph == slow_tick))
    else $error("wait clock gating wrong");
  a_halt_startup_len: assert property (
    (state_reg == PSM_HALT) && wake_irq && !startup_long_option
      |=> (state_reg == PSM_STARTUP) [*8] ##248 (state_reg == PSM_STARTUP) ##1
          (state_reg == PSM_RUN))
    else $error("halt start-up delay not 256 cycles");
  a_active_no_delay: assert property (
    (state_reg == PSM_ACTIVE_HALT) && rtc_irq |=> (state_reg == PSM_RUN) && cpu_resume)
    else $error("active-halt exit delayed");
  a_flag_read_clear: assert property (
    rd_csr && !awu_done |=> !auto_wake_flag_reg && !auto_wake_irq)
    else $error("status read did not clear flag");
  a_awu_sets_flag: assert property (
    awu_done |=> auto_wake_flag_reg && (state_reg == PSM_STARTUP))
    else $error("auto-wake terminal count lost");
  a_wdg_on_halt: assert property (
    (state_reg == PSM_RUN) && !wait_exec && halt_exec && !osc_irq_enable && wdg_on_halt
      |=> watchdog_reset_req && (state_reg == PSM_RUN))
    else $error("watchdog reset not requested");
  a_slow_divide: assert property (
    (state_reg == PSM_RUN) && slow_select_bit && (slow_divider_select == 2'h0)
      && clk_gate.cpu && !wr_main |=> !clk_gate.cpu)
    else $error("slow divide by two broken");
  a_measure_run: assert property (
    (state_reg != PSM_RUN) |=> !timer_capture_input_one)
    else $error("capture routed outside run mode");

  c_wait_wake: cover property ((state_reg == PSM_WAIT) ##1 (state_reg == PSM_RUN));
  c_awu_wake: cover property (awu_done ##1 (state_reg == PSM_STARTUP));
  c_active_exit: cover property ((state_reg == PSM_ACTIVE_HALT) ##1 (state_reg == PSM_RUN));
  c_flag_race: cover property (awu_done && rd_csr);

endmodule
`default_nettype wire

// *** psm_pkg.sv ***
// Package of constants and types for the power saving mode controller
`default_nettype none
package psm_pkg;
  // Register addresses
  localparam logic [7:0] PSM_ADDR_MAIN_CLK  = 8'h2d;
  localparam logic [7:0] PSM_ADDR_AWU_CSR   = 8'h2b;
  localparam logic [7:0] PSM_ADDR_AWU_PRESC = 8'h2c;
  // Main clock control fields
  localparam int PSM_SLOW_SEL_BIT  = 0;
  localparam int PSM_SLOW_DIV_LSB  = 1;
  localparam int PSM_OSC_IRQ_BIT   = 3;
  // Auto-wake control fields
  localparam int PSM_AWU_EN_BIT    = 0;
  localparam int PSM_AWU_MEAS_BIT  = 1;
  localparam int PSM_AWU_FLAG_BIT  = 2;
  // Reset values
  localparam logic [3:0] PSM_MAIN_CLK_RST  = 4'h0;
  localparam logic [1:0] PSM_AWU_CSR_RST   = 2'h0;
  localparam logic [7:0] PSM_AWU_PRESC_RST = 8'hff;
  // Decoded opcode and forced mask levels
  localparam logic [7:0] PSM_HALT_OPCODE   = 8'h8e;
  localparam logic [1:0] PSM_MASK_ENABLE   = 2'h2;
  localparam logic [1:0] PSM_MASK_CLEARED  = 2'h0;
  // Start-up delays in master clock cycles and auto-wake fixed divider
  localparam int PSM_STARTUP_SHORT = 256;
  localparam int PSM_STARTUP_LONG  = 4096;
  localparam logic [12:0] PSM_SHORT_CNT = 13'(PSM_STARTUP_SHORT - 1);
  localparam logic [12:0] PSM_LONG_CNT  = 13'(PSM_STARTUP_LONG - 1);
  localparam logic [13:0] PSM_AWU_FIXED_DIV = 14'h0040;

  typedef enum logic [2:0] {
    PSM_RUN,
    PSM_WAIT,
    PSM_HALT,
    PSM_ACTIVE_HALT,
    PSM_AWU_HALT,
    PSM_STARTUP
  } psm_state_type;

  // Clock gating group
  typedef struct packed {
    logic cpu;
    logic periph;
    logic rtc;
    logic osc;
  } psm_clk_gate_type;

  // Interrupt mask forcing group
  typedef struct packed {
    logic       load;
    logic [1:0] level;
  } psm_mask_force_type;
endpackage
`default_nettype wire

// *** psm_core_model.sv ***
// Processor core model issuing halt, wait and ordinary instructions
`default_nettype none
module psm_core_model
  import psm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       cpu_clk_en,
  input  wire logic [1:0] cmd,
  output logic            instr_valid,
  output logic [7:0]      instr_opcode,
  output logic            sleep_until_irq_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pend_reg;
  // A stalled core cannot execute, so commands wait for a processor tick
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_reg              <= 2'h0;
      instr_valid           <= 1'b0;
      instr_opcode          <= 8'h00;
      sleep_until_irq_instr <= 1'b0;
    end
    else
    begin
      instr_valid           <= 1'b0;
      sleep_until_irq_instr <= 1'b0;
      instr_opcode          <= ~instr_opcode; // Junk between instructions
      if (cmd != 2'h0)
        pend_reg <= cmd;
      else if (pend_reg != 2'h0 && cpu_clk_en)
      begin
        pend_reg              <= 2'h0;
        sleep_until_irq_instr <= (pend_reg == 2'h1);
        instr_valid           <= (pend_reg != 2'h1);
        instr_opcode          <= (pend_reg == 2'h2) ? PSM_HALT_OPCODE : 8'h8f;
      end
    end
  end
endmodule
`default_nettype wire

// *** psm_ctrl_tb_top.sv ***
// Self-checking bench for the power saving mode controller
`default_nettype none
module psm_ctrl_tb_top
  import psm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock, rstn, reg_write, reg_read, instr_valid, sleep_until_irq_instr;
  logic               irq_pending, wake_irq, rtc_irq, watchdog_enabled, watchdog_halt_option;
  logic               startup_long_option, rc_osc_clk, cpu_resume, watchdog_reset_req;
  logic               rc_osc_enable, auto_wake_irq, timer_capture_input_one;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata, instr_opcode;
  logic [1:0]         cmd;
  psm_clk_gate_type   clk_gate;
  psm_mask_force_type mask_force;
  int                 errors, num_checks, cycles, rc_edges, awu_edges, cap_edges, n, osc_n, a, b;

  psm_ctrl dut_u (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .instr_valid, .instr_opcode, .sleep_until_irq_instr, .irq_pending, .wake_irq, .rtc_irq,
    .watchdog_enabled, .watchdog_halt_option, .startup_long_option, .rc_osc_clk, .clk_gate,
    .mask_force, .cpu_resume, .watchdog_reset_req, .rc_osc_enable, .auto_wake_irq,
    .timer_capture_input_one);
  psm_core_model core_u (.clock, .rstn, .cpu_clk_en(clk_gate.cpu), .cmd, .instr_valid,
    .instr_opcode, .sleep_until_irq_instr);

  // Master clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // RC oscillator stands still while the design keeps it disabled
  initial
  begin
    rc_osc_clk = 1'b0;
    forever #37 if (rc_osc_enable) rc_osc_clk = ~rc_osc_clk;
  end
  // Edge counters and hang guard
  always @(posedge rc_osc_clk) rc_edges++;
  always @(posedge auto_wake_irq) awu_edges = rc_edges;
  always @(posedge timer_capture_input_one) cap_edges++;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(16'(reg_rdata), 16'(exp));
  endtask
  // Returns just after the edge at which the design takes the instruction
  task automatic issue(input logic [1:0] c);
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    cmd <= 2'h0;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clock);
      if (instr_valid || sleep_until_irq_instr)
        break;
    end
    #1;
  endtask
  // Counts cycles until the processor clock returns, and start-up cycles among them
  task automatic wait_run();
    n = 0;
    osc_n = 0;
    while (!clk_gate.cpu && n < 9000)
    begin
      @(posedge clock);
      #1 n++;
      if (clk_gate.osc && !clk_gate.cpu)
        osc_n++;
    end
  endtask
  task automatic count64();
    a = 0;
    b = 0;
    repeat (64)
    begin
      @(posedge clock);
      #1 a += clk_gate.cpu;
      b += clk_gate.periph;
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rstn, reg_write, reg_read, irq_pending, wake_irq, rtc_irq, cmd} = '0;
    {watchdog_enabled, watchdog_halt_option, startup_long_option} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    wait_run();
    rd(PSM_ADDR_MAIN_CLK, 8'h00);
    rd(PSM_ADDR_AWU_CSR, 8'h00);
    rd(PSM_ADDR_AWU_PRESC, 8'hff);
    rd(8'h00, 8'h00);
    // Every slow divider setting
    for (int k = 3; k >= 0; k--)
    begin
      wr(PSM_ADDR_MAIN_CLK, 8'(k * 2 + 1));
      rd(PSM_ADDR_MAIN_CLK, 8'(k * 2 + 1));
      count64();
      check(16'(a), 16'(32 >> k));
      check(16'(b), 16'(32 >> k));
    end
    // Slow-wait, woken by an ordinary interrupt
    issue(2'h1);
    check(16'(mask_force), 16'({1'b1, PSM_MASK_ENABLE}));
    count64();
    check(16'(a), 16'h0);
    check(16'(b), 16'd32);
    check(16'(clk_gate.osc), 16'h1);
    @(posedge clock);
    irq_pending <= 1'b1;
    wait_run();
    check(16'(n <= 3), 16'h1);
    @(posedge clock);
    irq_pending <= 1'b0;
    rd(PSM_ADDR_MAIN_CLK, 8'h01);
    wr(PSM_ADDR_MAIN_CLK, 8'h00);
    issue(2'h3);
    check(16'(clk_gate), 16'hf);
    // Plain halt, short then long start-up; second pass has a wake pending at entry
    for (int k = 0; k < 2; k++)
    begin
      startup_long_option <= k[0];
      wake_irq <= k[0];
      issue(2'h2);
      check(16'(mask_force), 16'({1'b1, PSM_MASK_ENABLE}));
      check(16'(clk_gate), 16'h0);
      if (k == 0)
      begin
        @(posedge clock);
        wake_irq <= 1'b1;
      end
      wait_run();
      check(16'(osc_n), k ? 16'd4096 : 16'd256);
      a = cpu_resume; // Pulse stands with the first run cycle
      @(posedge clock);
      wake_irq <= 1'b0;
      #1 check(16'(a), 16'h1);
      check(16'(cpu_resume), 16'h0);
    end
    // Watchdog option turns halt into a reset request
    watchdog_enabled <= 1'b1;
    issue(2'h2);
    a = watchdog_reset_req;
    @(posedge clock);
    #1 check(16'(a | watchdog_reset_req), 16'h1);
    check(16'(clk_gate.cpu), 16'h1);
    // Active-halt with the watchdog still on
    wr(PSM_ADDR_MAIN_CLK, 8'h08);
    issue(2'h2);
    check(16'(mask_force), 16'({1'b1, PSM_MASK_CLEARED}));
    check(16'(clk_gate), 16'h3);
    a = watchdog_reset_req;
    @(posedge clock);
    rtc_irq <= 1'b1;
    #1 check(16'(a | watchdog_reset_req), 16'h0);
    wait_run();
    check(16'(n <= 2), 16'h1);
    @(posedge clock);
    rtc_irq <= 1'b0;
    watchdog_enabled <= 1'b0;
    startup_long_option <= 1'b0; // Short start-up expected after auto-wake
    // Auto-wake halt with the smallest legal prescaler
    wr(PSM_ADDR_MAIN_CLK, 8'h00);
    wr(PSM_ADDR_AWU_PRESC, 8'h01);
    wr(PSM_ADDR_AWU_CSR, 8'h01);
    rc_edges = 0;
    issue(2'h2);
    check(16'(mask_force), 16'({1'b1, PSM_MASK_ENABLE}));
    check(16'({clk_gate, rc_osc_enable}), 16'h1);
    wait_run();
    check(16'(osc_n), 16'd256);
    check(16'(awu_edges >= 64 && awu_edges <= 66), 16'h1);
    rd(PSM_ADDR_AWU_CSR, 8'h05);
    rd(PSM_ADDR_AWU_CSR, 8'h01);
    check(16'(auto_wake_irq), 16'h0);
    // Measurement routes the RC clock to the capture input; flag stays read-only
    wr(PSM_ADDR_AWU_CSR, 8'hfe);
    rd(PSM_ADDR_AWU_CSR, 8'h02);
    cap_edges = 0;
    repeat (200) @(posedge clock);
    check(16'(cap_edges > 0 && rc_osc_enable), 16'h1);
    wr(PSM_ADDR_AWU_CSR, 8'h00);
    results();
  end
endmodule
`default_nettype wire
